// >>> rtl/rsg_pkg.sv
package rsg_pkg;
	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned SCALE_DIV     = 100;
	localparam logic [6:0]  SCALE_DIV_MAX = 7'(SCALE_DIV - 1);
	localparam logic [4:0]  MULT_STEPS    = 5'h10;
	localparam logic [4:0]  CONV_STEPS    = 5'h10;
	localparam logic [17:0] PCT_FULL      = 18'h1_86A0; // 100000 = 100.000 percent

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_DELAY    = 8'h04;
	localparam logic [7:0] OFF_WIDTH    = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0C;
	localparam logic [7:0] OFF_PERIOD   = 8'h10;
	localparam logic [7:0] OFF_FRACTION = 8'h14;

	// ==========================================================
	// field positions and reset values
	localparam int unsigned CTRL_MODE_LO   = 0;
	localparam int unsigned CTRL_PASSAGE   = 2;
	localparam int unsigned CTRL_CONVERT   = 3;
	localparam logic [1:0]  MODE_RST       = 2'h0;
	localparam logic [19:0] DELAY_RST      = 20'h0_0000;
	localparam logic [11:0] WIDTH_RST      = 12'h001;
	localparam logic [15:0] PERIOD_MAX     = 16'hFFFF;

	// ==========================================================
	// operating selector and sequencer phases
	typedef enum logic [1:0] {
		MODE_SCALE1,
		MODE_SCALE100,
		MODE_CONTINUOUS_GATE_SETTING,
		MODE_SPARE
	} rsg_mode_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_SPEED,
		PH_DELAY,
		PH_GATE
	} rsg_phase_t;

	// apb request side bundled
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} rsg_apb_req_t;
endpackage

// >>> rtl/rsg_bcd_digit.sv
`timescale 1ns/100ps
// one decade of a loadable bcd down counter with borrow chaining
module rsg_bcd_digit (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       load,
	input  wire logic [3:0] load_val,
	input  wire logic       dec_in,
	output logic      [3:0] digit,
	output logic            borrow_out
);
	logic [3:0] digit_r;

	// borrow goes to the next decade when this one wraps
	assign borrow_out = dec_in && (digit_r == 4'h0);
	assign digit      = digit_r;

	// load wins over counting
	always_ff @(posedge clock) begin
		if (rst) begin
			digit_r <= 4'h0;
		end else if (load) begin
			digit_r <= (load_val > 4'h9) ? 4'h9 : load_val;
		end else if (dec_in) begin
			digit_r <= (digit_r == 4'h0) ? 4'h9 : digit_r - 4'h1;
		end
	end
endmodule // rsg_bcd_digit

// >>> rtl/rsg_gate_timing_controller.sv
`timescale 1ns/100ps
module rsg_gate_timing_controller
	import rsg_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire rsg_pkg::rsg_apb_req_t apb_req,
	output logic                [31:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  rev_trigger,
	input  wire logic                  blade_trigger,
	output logic                       gate_out,
	output logic                       overflow_led
);
	import rsg_pkg::*;

	// ==========================================================
	// register file
	rsg_mode_t   mode_r;
	logic        passage_r;
	logic [19:0] delay_pct_r;
	logic [11:0] width_set_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;

	// ==========================================================
	// sequencer state
	rsg_phase_t  phase_r;
	logic        rev_d_r;
	logic        blade_d_r;
	logic [15:0] period_cnt_r;
	logic [15:0] period_r;
	logic        ovf_seen_r;
	logic        overflow_r;
	logic [15:0] fraction_r;
	logic        frac_valid_r;
	logic        conv_busy_r;
	logic [4:0]  conv_cnt_r;
	logic [17:0] conv_rem_r;
	logic        mult_busy_r;
	logic [4:0]  mult_cnt_r;
	logic [31:0] prod_r;
	logic [15:0] delay_load_r;
	logic        delay_ready_r;
	logic [15:0] delay_cnt_r;
	logic        delay_run_r;
	logic        dummy_r;
	logic        gate_r;
	logic        gate_out_r;
	logic        pp_armed_r;
	logic        pp_block_r;
	logic [6:0]  div_cnt_r;

	// ==========================================================
	// apb decode
	wire access   = apb_req.psel && apb_req.penable && !pready_r;
	wire done     = apb_req.psel && apb_req.penable && pready_r;
	wire hit      = (apb_req.paddr == OFF_CTRL) || (apb_req.paddr == OFF_DELAY)
	             || (apb_req.paddr == OFF_WIDTH) || (apb_req.paddr == OFF_STATUS)
	             || (apb_req.paddr == OFF_PERIOD) || (apb_req.paddr == OFF_FRACTION);
	wire wr_en    = done && apb_req.pwrite && !pslverr_r;
	wire wr_ctrl  = wr_en && (apb_req.paddr == OFF_CTRL);
	wire convert  = wr_ctrl && apb_req.pwdata[CTRL_CONVERT];
	wire [1:0] mode_wr = apb_req.pwdata[CTRL_MODE_LO +: 2];

	// read mux, status shows the sequencer's own state
	logic [31:0] rd_mux;
	always_comb begin
		case (apb_req.paddr)
			OFF_CTRL:     rd_mux = {28'h000_0000, 1'b0, passage_r, mode_r};
			OFF_DELAY:    rd_mux = {12'h000, delay_pct_r};
			OFF_WIDTH:    rd_mux = {20'h0_0000, width_set_r};
			OFF_STATUS:   rd_mux = {26'h000_0000, conv_busy_r, frac_valid_r,
			                        phase_r, gate_r, overflow_r};
			OFF_PERIOD:   rd_mux = {16'h0000, period_r};
			OFF_FRACTION: rd_mux = {16'h0000, fraction_r};
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait state, answer and error registered
	always_ff @(posedge clock) begin
		if (rst) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= access;
			pslverr_r <= access && !hit;
			if (access && !apb_req.pwrite) begin
				prdata_r <= rd_mux;
			end
		end
	end

	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign prdata  = prdata_r;

	// operator settings; reserved mode code folds to scale 1
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_r      <= rsg_mode_t'(MODE_RST);
			passage_r   <= 1'b0;
			delay_pct_r <= DELAY_RST;
			width_set_r <= WIDTH_RST;
		end else if (wr_en) begin
			if (wr_ctrl) begin
				mode_r    <= (mode_wr == MODE_SPARE) ? MODE_SCALE1 : rsg_mode_t'(mode_wr);
				passage_r <= apb_req.pwdata[CTRL_PASSAGE];
			end
			if (apb_req.paddr == OFF_DELAY) begin
				delay_pct_r <= apb_req.pwdata[19:0];
			end
			if (apb_req.paddr == OFF_WIDTH) begin
				width_set_r <= apb_req.pwdata[11:0];
			end
		end
	end

	// ==========================================================
	// trigger edges and mode changes
	wire continuous_gate_setting      = (mode_r == MODE_CONTINUOUS_GATE_SETTING);
	wire leave     = wr_ctrl && continuous_gate_setting && (mode_wr != MODE_CONTINUOUS_GATE_SETTING);
	wire rev_edge  = rev_trigger && !rev_d_r;
	wire trig      = rev_edge && !continuous_gate_setting;
	wire blade_edge = blade_trigger && !blade_d_r;
	wire period_ovf = (phase_r == PH_SPEED) && (period_cnt_r == PERIOD_MAX);

	always_ff @(posedge clock) begin
		if (rst) begin
			rev_d_r   <= 1'b0;
			blade_d_r <= 1'b0;
		end else begin
			rev_d_r   <= rev_trigger;
			blade_d_r <= blade_trigger;
		end
	end

	// modulo-three phase counter with an idle entry state
	always_ff @(posedge clock) begin
		if (rst) begin
			phase_r <= PH_IDLE;
		end else if (leave) begin
			phase_r <= PH_IDLE;
		end else if (trig) begin
			case (phase_r)
				PH_IDLE:  phase_r <= PH_SPEED;
				PH_SPEED: phase_r <= PH_DELAY;
				PH_DELAY: phase_r <= PH_GATE;
				PH_GATE:  phase_r <= PH_SPEED;
				default:  phase_r <= PH_IDLE;
			endcase
		end
	end

	// ==========================================================
	// speed phase: period counter, capture and overflow
	wire start_speed = trig && ((phase_r == PH_IDLE) || (phase_r == PH_GATE));
	wire capture     = trig && (phase_r == PH_SPEED);

	always_ff @(posedge clock) begin
		if (rst) begin
			period_cnt_r <= 16'h0000;
			period_r     <= 16'h0000;
			ovf_seen_r   <= 1'b0;
			overflow_r   <= 1'b0;
		end else begin
			if (start_speed) begin
				period_cnt_r <= 16'h0000;
				ovf_seen_r   <= 1'b0;
			end else if (phase_r == PH_SPEED) begin
				period_cnt_r <= period_cnt_r + 16'h0001;
				if (period_ovf) begin
					ovf_seen_r <= 1'b1;
				end
			end
			if (capture) begin
				period_r <= period_cnt_r;
			end
			// set wins over the clear at a clean capture
			if (period_ovf) begin
				overflow_r <= 1'b1;
			end else if (capture && !ovf_seen_r) begin
				overflow_r <= 1'b0;
			end
		end
	end

	assign overflow_led = overflow_r;

	// ==========================================================
	// percent to fraction conversion by restoring division
	logic [16:0] pct_bin;
	always_comb begin
		pct_bin = 17'(delay_pct_r[3:0])
		        + 17'(delay_pct_r[7:4]) * 17'd10
		        + 17'(delay_pct_r[11:8]) * 17'd100
		        + 17'(delay_pct_r[15:12]) * 17'd1000
		        + 17'(delay_pct_r[19:16]) * 17'd10000;
	end

	wire [17:0] rem2 = {conv_rem_r[16:0], 1'b0};
	wire        qbit = (rem2 >= PCT_FULL);

	always_ff @(posedge clock) begin
		if (rst) begin
			conv_busy_r  <= 1'b0;
			conv_cnt_r   <= 5'h00;
			conv_rem_r   <= 18'h0_0000;
			fraction_r   <= 16'h0000;
			frac_valid_r <= 1'b0;
		end else if (convert && !conv_busy_r) begin
			conv_busy_r  <= 1'b1;
			conv_cnt_r   <= 5'h00;
			conv_rem_r   <= {1'b0, pct_bin};
			frac_valid_r <= 1'b0;
		end else if (conv_busy_r) begin
			conv_rem_r <= qbit ? rem2 - PCT_FULL : rem2;
			fraction_r <= {fraction_r[14:0], qbit};
			conv_cnt_r <= conv_cnt_r + 5'h01;
			if (conv_cnt_r == CONV_STEPS - 5'h01) begin
				conv_busy_r  <= 1'b0;
				frac_valid_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// delay phase: serial shift-and-add multiply, keep upper half
	always_ff @(posedge clock) begin
		if (rst) begin
			mult_busy_r   <= 1'b0;
			mult_cnt_r    <= 5'h00;
			prod_r        <= 32'h0000_0000;
			delay_load_r  <= 16'h0000;
			delay_ready_r <= 1'b0;
		end else if (capture) begin
			mult_busy_r   <= 1'b1;
			mult_cnt_r    <= 5'h00;
			prod_r        <= 32'h0000_0000;
			delay_ready_r <= 1'b0;
		end else if (mult_busy_r) begin
			if (fraction_r[mult_cnt_r[3:0]]) begin
				prod_r <= prod_r + ({16'h0000, period_r} << mult_cnt_r);
			end
			mult_cnt_r <= mult_cnt_r + 5'h01;
			if (mult_cnt_r == MULT_STEPS) begin
				mult_busy_r   <= 1'b0;
				delay_load_r  <= prod_r[31:16];
				delay_ready_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// gate phase: delay counter, gate flip-flop, width counter
	wire start_gate = trig && (phase_r == PH_DELAY);
	wire arm_delay  = start_gate && !overflow_r && !gate_r && delay_ready_r;
	wire carry      = delay_run_r && (delay_cnt_r == 16'h0000);
	wire in_gate    = (phase_r == PH_GATE) && !dummy_r;
	wire reopen     = passage_r && pp_armed_r && !pp_block_r && in_gate
	               && blade_edge && !gate_r;
	wire open_evt   = carry || reopen;
	wire tick100    = (div_cnt_r == SCALE_DIV_MAX);
	wire step_en    = (mode_r == MODE_SCALE100) ? tick100 : 1'b1;
	logic [11:0] width_now;
	logic [3:0]  borrow;
	wire wzero      = (width_now == 12'h000);
	wire wstep      = gate_r && !wzero && step_en;
	wire wdone      = gate_r && wzero && !open_evt;

	always_ff @(posedge clock) begin
		if (rst || leave) begin
			delay_run_r <= 1'b0;
			delay_cnt_r <= 16'h0000;
			dummy_r     <= 1'b0;
		end else begin
			if (start_gate) begin
				dummy_r <= gate_r;
			end
			if (arm_delay) begin
				delay_cnt_r <= delay_load_r;
				delay_run_r <= 1'b1;
			end else if (carry) begin
				delay_run_r <= 1'b0;
			end else if (delay_run_r) begin
				delay_cnt_r <= delay_cnt_r - 16'h0001;
			end
		end
	end

	// gate opens on carry or a per-passage reopen, closes when the width runs out or on leaving continuous mode
	always_ff @(posedge clock) begin
		if (rst || leave) begin
			gate_r <= 1'b0;
		end else if (open_evt) begin
			gate_r <= 1'b1;
		end else if (wdone) begin
			gate_r <= 1'b0;
		end
	end

	// divide-by-100 prescaler restarted at every gate opening
	always_ff @(posedge clock) begin
		if (rst || open_evt || tick100) begin
			div_cnt_r <= 7'h00;
		end else begin
			div_cnt_r <= div_cnt_r + 7'h01;
		end
	end

	// per-passage arming; a passage seen while open blocks the rest
	always_ff @(posedge clock) begin
		if (rst || leave || (phase_r != PH_GATE)) begin
			pp_armed_r <= 1'b0;
			pp_block_r <= 1'b0;
		end else begin
			if (carry && passage_r) begin
				pp_armed_r <= 1'b1;
			end
			if (pp_armed_r && blade_edge && gate_r) begin
				pp_block_r <= 1'b1;
			end
		end
	end

	// three decades preset from the width setting
	assign borrow[0] = wstep;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_dec
			rsg_bcd_digit u_digit (
				.clock      (clock),
				.rst        (rst),
				.load       (open_evt),
				.load_val   (width_set_r[gi*4 +: 4]),
				.dec_in     (borrow[gi]),
				.digit      (width_now[gi*4 +: 4]),
				.borrow_out (borrow[gi+1])
			);
		end
	endgenerate

	// registered gate output, forced on in continuous mode
	always_ff @(posedge clock) begin
		if (rst) begin
			gate_out_r <= 1'b0;
		end else begin
			gate_out_r <= continuous_gate_setting || (gate_r && !open_evt) || open_evt;
		end
	end

	assign gate_out = gate_out_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence leave_continuous_gate_setting_s;
		continuous_gate_setting ##1 !continuous_gate_setting;
	endsequence

	sequence speed_end_s;
		trig && (phase_r == PH_SPEED);
	endsequence

	reset_state_a: assert property (@(posedge clock) disable iff (1'b0)
		rst |=> (!gate_r && !overflow_r && (phase_r == PH_IDLE)))
		else $error("reset state wrong");
	continuous_gate_setting_gate_a: assert property (continuous_gate_setting |=> gate_out)
		else $error("gate not held open in continuous mode");
	continuous_gate_setting_block_a: assert property (continuous_gate_setting && rev_edge && !leave |=> $stable(phase_r))
		else $error("trigger reached phase counter in continuous mode");
	reinit_a: assert property (leave_continuous_gate_setting_s |-> (phase_r == PH_IDLE))
		else $error("phase counter not reinitialised");
	phase_order_a: assert property (trig && (phase_r == PH_DELAY) |=> phase_r == PH_GATE)
		else $error("phase order broken");
	ovf_set_a: assert property (period_ovf |=> overflow_led)
		else $error("overflow not indicated");
	ovf_inhibit_a: assert property (start_gate && overflow_r |=> !delay_run_r)
		else $error("gate phase ran during overflow");
	mult_bound_a: assert property (speed_end_s |-> ##[1:20] delay_ready_r)
		else $error("product not ready in time");
	carry_open_a: assert property (carry |=> gate_r ##1 gate_out)
		else $error("carry did not open gate");
	width_close_a: assert property (gate_r && !wzero && !wstep && !leave |=> gate_r)
		else $error("gate closed before width ran out");
	dummy_hold_a: assert property (start_gate && gate_r |=> !delay_run_r)
		else $error("dummy phase restarted the delay");
	scale_step_a: assert property (gate_r && (mode_r == MODE_SCALE100)
		&& !tick100 && !open_evt |=> $stable(width_now))
		else $error("width counted off prescaler");
	block_first_a: assert property (pp_block_r && blade_edge && !gate_r |=> !gate_r)
		else $error("gate reopened after pitch exceeded");
endmodule // rsg_gate_timing_controller

// >>> dv/rsg_blade_sensor_model.sv
`timescale 1ns/100ps
// optical rotor sensor: one revolution pulse per period, evenly spaced blade pulses
module rsg_blade_sensor_model #(
	parameter int BLADES = 4
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic [16:0] period,
	output logic             rev_trigger,
	output logic             blade_trigger
);
	// ==========================================================
	// revolution position
	logic [16:0] pos_r;
	logic [16:0] pitch;

	// blade pitch in clock cycles, half a pitch offset from the revolution mark
	assign pitch = period / 17'(BLADES);

	// comparator outputs idle low between passages; one cycle high per passage
	always_ff @(posedge clock) begin
		if (rst || !run) begin
			pos_r         <= '0;
			rev_trigger   <= 1'b0;
			blade_trigger <= 1'b0;
		end else begin
			pos_r         <= (pos_r >= period - 17'd1) ? '0 : pos_r + 17'd1;
			rev_trigger   <= (pos_r == '0);
			blade_trigger <= ((pos_r % pitch) == (pitch >> 1));
		end
	end
endmodule // rsg_blade_sensor_model

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
	import rsg_pkg::*;
	// ==========================================================
	// stimulus and observation
	logic         clock = 1'b0;
	logic         rst = 1'b1;
	logic         run = 1'b0;
	logic [16:0]  period = 17'd66000;
	rsg_apb_req_t req = '0;
	logic [31:0]  prdata;
	logic         pready, pslverr, rev_trigger, blade_trigger, gate_out, overflow_led;
	logic         rev_q = 1'b0;
	logic         gate_q = 1'b0;
	logic [31:0]  q;
	logic         e;
	logic [1:0]   ph;
	int           mismatches = 0;
	int           comparisons = 0;
	int           cyc = 0, trig_n = 0, trig_at = 0, rises = 0, rise_at = 0, fall_at = 0;
	int           d, w, n0, frac, dexp;

	always #25 clock = ~clock;

	rsg_gate_timing_controller u_dut (.clock(clock), .rst(rst), .apb_req(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rev_trigger(rev_trigger),
		.blade_trigger(blade_trigger), .gate_out(gate_out), .overflow_led(overflow_led));

	rsg_blade_sensor_model u_sensor (.clock(clock), .rst(rst), .run(run), .period(period),
		.rev_trigger(rev_trigger), .blade_trigger(blade_trigger));

	// edge bookkeeping for the revolution trigger and gate
	always @(posedge clock) begin
		rev_q  <= rev_trigger;
		gate_q <= gate_out;
		cyc    <= cyc + 1;
		if (rev_trigger && !rev_q) begin
			trig_n  <= trig_n + 1;
			trig_at <= cyc;
		end
		if (gate_out && !gate_q) begin
			rises   <= rises + 1;
			rise_at <= cyc;
		end
		if (!gate_out && gate_q) begin
			fall_at <= cyc;
		end
	end

	// ==========================================================
	// helpers
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic hang();
		mismatches++;
		$display("[ERR] %0t wait ran out", $time);
		end_sim();
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask

	task automatic near(input int s, input int x, input int tol);
		chk(32'(s >= x - tol && s <= x + tol), 32'h0000_0001);
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv);
		int n;
		n = 0;
		@(posedge clock);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: dv};
		@(posedge clock);
		req.penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			hang();
		end
		q = prdata;
		e = pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, x);
	endtask

	task automatic wait_trig(input int t);
		int n;
		n = 0;
		while (trig_n < t && n < 70000) begin
			@(posedge clock);
			n++;
		end
		if (n >= 70000) begin
			hang();
		end
	endtask

	// waits for one whole gate pulse, delay taken from the last revolution pulse
	task automatic gate_pulse();
		int n, k;
		n = rises;
		k = 0;
		while ((rises == n || fall_at <= rise_at) && k < 10000) begin
			@(posedge clock);
			k++;
		end
		if (k >= 10000) begin
			hang();
		end
		d = rise_at - trig_at;
		w = fall_at - rise_at;
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		hang();
	end

	// ==========================================================
	// main sequence
	initial begin
		int n;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		chk({gate_out, overflow_led}, 32'h0000_0000);
		rd(OFF_STATUS, 32'h0000_0000);
		rd(OFF_WIDTH, 32'h0000_0001);
		rd(8'h18, 32'h0000_0000);
		chk(e, 32'h0000_0001);
		$display("test reset done");

		frac = 1000 * 65536 / 100000;
		apb(1'b1, OFF_DELAY, 32'h0000_1000);
		rd(OFF_FRACTION, 32'h0000_0000);
		apb(1'b1, OFF_CTRL, 32'h0000_0008);
		n = 0;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0000_0000);
			n++;
		end while (q[4] !== 1'b1 && n < 40);
		if (q[4] !== 1'b1) begin
			hang();
		end
		rd(OFF_FRACTION, 32'(frac));
		$display("test conversion done");

		run <= 1'b1;
		wait_trig(2);
		repeat (4) @(posedge clock);
		chk(overflow_led, 32'h0000_0001);
		rd(OFF_PERIOD, 32'h0000_01CF);
		period <= 17'd600;
		wait_trig(3);
		n0 = rises;
		wait_trig(4);
		chk(32'(rises - n0), 32'h0000_0000);
		wait_trig(5);
		repeat (4) @(posedge clock);
		chk(overflow_led, 32'h0000_0000);
		apb(1'b0, OFF_PERIOD, 32'h0000_0000);
		near(int'(q), 599, 2);
		dexp = (599 * frac) >> 16;
		wait_trig(6);
		gate_pulse();
		near(d, dexp + 4, 4);
		near(w, 1, 2);
		$display("test overflow and delay done");

		apb(1'b1, OFF_WIDTH, 32'h0000_0020);
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		wait_trig(9);
		n0 = rises;
		gate_pulse();
		near(w, 2000, 4);
		wait_trig(14);
		chk(32'(rises - n0), 32'h0000_0001);
		$display("test scale and dummy gate done");

		apb(1'b1, OFF_WIDTH, 32'h0000_0016);
		apb(1'b1, OFF_CTRL, 32'h0000_0004);
		wait_trig(15);
		n0 = rises;
		wait_trig(16);
		chk(32'(rises - n0 >= 4), 32'h0000_0001);
		apb(1'b1, OFF_WIDTH, 32'h0000_0200);
		wait_trig(18);
		n0 = rises;
		wait_trig(19);
		chk(32'(rises - n0), 32'h0000_0001);
		$display("test per passage done");

		apb(1'b1, OFF_CTRL, 32'h0000_0002);
		repeat (3) @(posedge clock);
		chk(gate_out, 32'h0000_0001);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		ph = q[3:2];
		wait_trig(trig_n + 2);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(q[3:2], ph);
		apb(1'b1, OFF_CTRL, 32'h0000_0000);
		rd(OFF_STATUS, 32'h0000_0010);
		wait_trig(trig_n + 1);
		repeat (3) @(posedge clock);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(q[3:2], 32'h0000_0001);
		$display("test continuous done");
		end_sim();
	end
endmodule // tb
